// *** verilog/plb_pkg.sv ***
/*
 * Package for the programmable logic block: sizes, register offsets,
 * configuration field layouts and reset values.
 * Assumes a single clock domain at 125 MHz and an AXI4-Lite register bus.
 */
package plb_pkg;
	localparam int PLB_NIN = 59;
	localparam int PLB_NBUS = 61;
	localparam int PLB_NSEL = 8;
	localparam int PLB_NPA_PT = 6;
	localparam int PLB_NPB_PT = 10;
	localparam int PLB_NCELL = 8;
	localparam int PLB_NGLOB = 3;
	// Register byte offsets
	localparam logic [7:0] PLB_OFS_PTIDX = 8'h00;
	localparam logic [7:0] PLB_OFS_PTTRUE_LO = 8'h04;
	localparam logic [7:0] PLB_OFS_PTTRUE_HI = 8'h08;
	localparam logic [7:0] PLB_OFS_PTCOMP_LO = 8'h0C;
	localparam logic [7:0] PLB_OFS_PTCOMP_HI = 8'h10;
	localparam logic [7:0] PLB_OFS_PACFG = 8'h14;
	localparam logic [7:0] PLB_OFS_PBCFG = 8'h18;
	localparam logic [7:0] PLB_OFS_CTRL = 8'h1C;
	localparam logic [7:0] PLB_OFS_SEL = 8'h20;
	localparam logic [7:0] PLB_OFS_IOSEL = 8'h24;
	localparam logic [7:0] PLB_OFS_PORTS = 8'h28;
	localparam logic [7:0] PLB_OFS_PBCLK = 8'h2C;
	localparam logic [7:0] PLB_OFS_PBCLR = 8'h30;
	// Per-cell config field positions (4 bits per cell)
	localparam int PLB_CF_POL = 0;
	localparam int PLB_CF_REG = 1;
	localparam int PLB_CF_DIR0 = 2;
	localparam int PLB_CF_DIR1 = 3;
	localparam int PLB_CTRL_MRST_EN = 0;
	// Term count: 8 decode + 3 port A global + 8x6 + 8x10 + 8x3 port B
	localparam int PLB_NPT = 8 + 3 + 48 + 80 + 24;
	localparam int PLB_PT_PA_GLOB = 8;
	localparam int PLB_PT_PA_CELL = 11;
	localparam int PLB_PT_PB_CELL = 59;
	localparam int PLB_PT_PB_CTL = 139;
	localparam logic [31:0] PLB_RST_CFG = 32'h00000000;
	localparam logic [1:0] PLB_RESP_OKAY = 2'h0;
	localparam logic [1:0] PLB_RESP_SLVERR = 2'h2;
	// Pin direction codes
	typedef enum logic [1:0] {
		PLB_DIR_IN = 2'h0,
		PLB_DIR_OUT = 2'h1,
		PLB_DIR_BIDIR = 2'h2,
		PLB_DIR_BURIED = 2'h3
	} plb_dir_t;
endpackage : plb_pkg

// *** verilog/plb_cell_if.sv ***
/*
 * Interface carrying one port's macrocell controls from the top to a macrocell set.
 * Assumes the owner drives config and terms each cycle.
 */
`timescale 1ns/1ns
interface plb_cell_if #(parameter int NPT = 6);
	logic [8*NPT-1:0] terms;
	logic [31:0] cfg;
	logic [7:0] pre;
	logic [7:0] clr;
	logic [7:0] clk_sel;
	logic [7:0] cell_clk;
	logic [7:0] comb;
	logic [7:0] regv;
	modport owner (output terms, cfg, pre, clr, clk_sel, cell_clk, input comb, regv);
	modport cells (input terms, cfg, pre, clr, clk_sel, cell_clk, output comb, regv);
endinterface : plb_cell_if

// *** verilog/plb_macrocells.sv ***
/*
 * One set of eight macrocells: OR of product terms, polarity, D flip-flop.
 * Assumes async preset/clear and clocks are modelled as synchronous events on aclk.
 */
`timescale 1ns/1ns
module plb_macrocells
	import plb_pkg::*;
#(
	parameter int NPT = 6
) (
	input wire logic aclk,
	input wire logic ce,
	input wire logic clk_pin,
	plb_cell_if.cells mc
);
	logic [7:0] clk_q_ff;

	// Edge detection of selected clock source per cell
	always_ff @(posedge aclk) begin
		if (ce) begin
			clk_q_ff <= mc.clk_sel & mc.cell_clk | ~mc.clk_sel & {8{clk_pin}};
		end
	end

	for (genvar i = 0; i < 8; i++) begin : g_cell
		logic ck;
		logic d;
		assign ck = mc.clk_sel[i] ? mc.cell_clk[i] : clk_pin;
		assign d = (|mc.terms[i*NPT +: NPT]) ^ mc.cfg[4*i+PLB_CF_POL];
		assign mc.comb[i] = d;
		always_ff @(posedge aclk) begin
			if (ce) begin
				if (mc.clr[i]) begin
					mc.regv[i] <= 1'b0;
				end else if (mc.pre[i]) begin
					mc.regv[i] <= 1'b1;
				end else if (ck && !clk_q_ff[i]) begin
					mc.regv[i] <= d;
				end
			end
		end
	end

	clear_wins_a: assert property (@(posedge aclk) ce && mc.clr[0] |=> !mc.regv[0])
		else $error("clear did not clear cell 0");
	preset_sets_a: assert property (@(posedge aclk) ce && mc.pre[0] && !mc.clr[0] |=> mc.regv[0])
		else $error("preset did not set cell 0");
endmodule : plb_macrocells

// *** verilog/plb_top.sv ***
/*
 * Programmable logic block: address decode array, general array and
 * port A/B macrocells, configured over AXI4-Lite.
 * Assumes pins and address are synchronous to aclk; input clock pin sampled.
 */
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
// Notes on behaviour
// - Eight selects: four memory, sram, io, two peripheral
// - IO select decodes low eight address bits
// - Decode: 59 inputs, one term per output
// - Address bits 0,1,8-15 reach array
// - General array shares inputs, feeds port sets
// - Output pin driven by macrocell; in bidir mode a term enables it
// - Input pin routed onto 61-wide bus
// - Port A has eight macrocells
// - Port A global enable, preset, clear terms
// - Port A clocked only by input clock
// - Optional macrocell reset clears flip-flops
// - Port A cell: six terms, selectable polarity
// - Registered or combinational; pin direction configurable
// - Feedback register or combinational; buried frees pin
// - Port B eight cells, clock, reset reach
// - Port B cell: ten terms, selectable polarity
// - Port B preset only when term defined
// - Port B clear: reset or own term
// - Port B clock: input pin or term
`timescale 1ns/1ns
module plb_top
	import plb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [15:0] mcu_addr,
	input wire logic mcu_rd,
	input wire logic mcu_wr,
	input wire logic [3:0] page_bits,
	input wire logic input_clock_pin,
	input wire logic reset_pin,
	input wire logic chip_sel_in,
	input wire logic [7:0] portc_in,
	input wire logic [7:0] portd_in,
	input wire logic [7:0] porte_in,
	input wire logic [7:0] porta_in,
	output logic [7:0] porta_out,
	output logic [7:0] porta_oe,
	input wire logic [7:0] portb_in,
	output logic [7:0] portb_out,
	output logic [7:0] portb_oe,
	output logic [3:0] memory_block_select,
	output logic sram_block_select,
	output logic io_decoder_select,
	output logic [1:0] peripheral_mode_select,
	output logic [255:0] io_reg_select,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// Product term store: true and complement enables per term
	logic [PLB_NIN-1:0] pt_true_ff [PLB_NPT];
	logic [PLB_NIN-1:0] pt_comp_ff [PLB_NPT];
	logic [7:0] ptidx_ff;
	logic [31:0] pacfg_ff;
	logic [31:0] pbcfg_ff;
	logic [31:0] ctrl_ff;
	logic [7:0] pbclk_sel_ff;
	logic [7:0] pbclr_sel_ff;
	logic [PLB_NPT-1:0] pt;
	logic [PLB_NPT-1:0] pt_used;
	logic [PLB_NIN-1:0] in_bus;
	logic [PLB_NBUS-1:0] logic_bus;
	logic [7:0] pa_fb;
	logic [7:0] pb_fb;
	logic macrocell_reset;

	plb_cell_if #(.NPT(PLB_NPA_PT)) pa_if ();
	plb_cell_if #(.NPT(PLB_NPB_PT)) pb_if ();

	function automatic plb_dir_t cell_dir(input logic [31:0] cfg, input int i);
		return plb_dir_t'(cfg[4*i+PLB_CF_DIR0 +: 2]);
	endfunction : cell_dir

	function automatic logic [7:0] fb_sel(input logic [31:0] cfg,
		input logic [7:0] pin, input logic [7:0] regv, input logic [7:0] comb);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			// Input pin or macrocell feedback, register or combinational form
			if (cell_dir(cfg, i) == PLB_DIR_IN) begin
				r[i] = pin[i];
			end else begin
				r[i] = cfg[4*i+PLB_CF_REG] ? regv[i] : comb[i];
			end
		end
		return r;
	endfunction : fb_sel

	// Shared inputs: only address bits 0,1 and 8-15
	assign pa_fb = fb_sel(pacfg_ff, porta_in, pa_if.regv, pa_if.comb);
	assign pb_fb = fb_sel(pbcfg_ff, portb_in, pb_if.regv, pb_if.comb);
	assign in_bus = {chip_sel_in, reset_pin, input_clock_pin, mcu_wr, mcu_rd,
		mcu_addr[1:0], mcu_addr[15:8], page_bits, portd_in, portc_in, porte_in,
		pb_fb, pa_fb};
	// Port E side pins complete the 61-signal bus
	assign logic_bus = {porte_in[1:0], in_bus};

	// Each term: AND of selected true and complement inputs
	always_comb begin
		for (int t = 0; t < PLB_NPT; t++) begin
			pt_used[t] = |(pt_true_ff[t] | pt_comp_ff[t]);
			pt[t] = pt_used[t] && &((in_bus | ~pt_true_ff[t]) &
				(~in_bus | ~pt_comp_ff[t]));
		end
	end

	assign macrocell_reset = ctrl_ff[PLB_CTRL_MRST_EN] & reset_pin;

	// Port A: shared clock pin, global preset/clear
	assign pa_if.terms = pt[PLB_PT_PA_CELL +: 8*PLB_NPA_PT];
	assign pa_if.cfg = pacfg_ff;
	assign pa_if.pre = {8{pt[PLB_PT_PA_GLOB+1]}};
	assign pa_if.clr = {8{pt[PLB_PT_PA_GLOB+2] | macrocell_reset}};
	assign pa_if.clk_sel = 8'h00;
	assign pa_if.cell_clk = 8'h00;

	// Port B: per-cell preset, selectable clear and clock
	assign pb_if.terms = pt[PLB_PT_PB_CELL +: 8*PLB_NPB_PT];
	assign pb_if.cfg = pbcfg_ff;
	assign pb_if.clk_sel = pbclk_sel_ff;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pb_if.pre[i] = pt[PLB_PT_PB_CTL+3*i];
			pb_if.clr[i] = pbclr_sel_ff[i] ? pt[PLB_PT_PB_CTL+3*i+1] : macrocell_reset;
			pb_if.cell_clk[i] = pt[PLB_PT_PB_CTL+3*i+2];
		end
	end

	plb_macrocells #(.NPT(PLB_NPA_PT)) u_pa (
		.aclk(aclk),
		.ce(ce),
		.clk_pin(input_clock_pin),
		.mc(pa_if)
	);
	plb_macrocells #(.NPT(PLB_NPB_PT)) u_pb (
		.aclk(aclk),
		.ce(ce),
		.clk_pin(input_clock_pin),
		.mc(pb_if)
	);

	// Port pins: output mux and enable, registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			porta_out <= 8'h00;
			porta_oe <= 8'h00;
			portb_out <= 8'h00;
			portb_oe <= 8'h00;
		end else if (ce) begin
			for (int i = 0; i < 8; i++) begin
				porta_out[i] <= pacfg_ff[4*i+PLB_CF_REG] ? pa_if.regv[i] : pa_if.comb[i];
				portb_out[i] <= pbcfg_ff[4*i+PLB_CF_REG] ? pb_if.regv[i] : pb_if.comb[i];
				case (cell_dir(pacfg_ff, i))
					PLB_DIR_OUT: porta_oe[i] <= 1'b1;
					PLB_DIR_BIDIR: porta_oe[i] <= pt[PLB_PT_PA_GLOB];
					default: porta_oe[i] <= 1'b0;
				endcase
				case (cell_dir(pbcfg_ff, i))
					PLB_DIR_OUT: portb_oe[i] <= 1'b1;
					PLB_DIR_BIDIR: portb_oe[i] <= pt[PLB_PT_PB_CTL+3*i+1];
					default: portb_oe[i] <= 1'b0;
				endcase
			end
		end
	end

	// Decode selects and IO decoder
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			memory_block_select <= 4'h0;
			sram_block_select <= 1'b0;
			io_decoder_select <= 1'b0;
			peripheral_mode_select <= 2'h0;
			io_reg_select <= '0;
		end else if (ce) begin
			memory_block_select <= pt[3:0];
			sram_block_select <= pt[4];
			io_decoder_select <= pt[5];
			peripheral_mode_select <= pt[7:6];
			io_reg_select <= pt[5] ? (256'h1 << mcu_addr[7:0]) : '0;
		end
	end

	// AXI4-Lite slave
	logic aw_ok;
	logic [31:0] rd_val;
	assign aw_ok = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;

	always_comb begin
		case (s_axi_araddr)
			PLB_OFS_PTIDX: rd_val = {24'h000000, ptidx_ff};
			PLB_OFS_PTTRUE_LO: rd_val = pt_true_ff[ptidx_ff][31:0];
			PLB_OFS_PTTRUE_HI: rd_val = {5'h00, pt_true_ff[ptidx_ff][58:32]};
			PLB_OFS_PTCOMP_LO: rd_val = pt_comp_ff[ptidx_ff][31:0];
			PLB_OFS_PTCOMP_HI: rd_val = {5'h00, pt_comp_ff[ptidx_ff][58:32]};
			PLB_OFS_PACFG: rd_val = pacfg_ff;
			PLB_OFS_PBCFG: rd_val = pbcfg_ff;
			PLB_OFS_CTRL: rd_val = ctrl_ff;
			PLB_OFS_SEL: rd_val = {24'h000000, peripheral_mode_select, io_decoder_select,
				sram_block_select, memory_block_select};
			PLB_OFS_PORTS: rd_val = {16'h0000, pb_if.regv, pa_if.regv};
			PLB_OFS_PBCLK: rd_val = {24'h000000, pbclk_sel_ff};
			PLB_OFS_PBCLR: rd_val = {24'h000000, pbclr_sel_ff};
			default: rd_val = 32'h00000000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PLB_RESP_OKAY;
		end else if (ce) begin
			s_axi_awready <= aw_ok && !s_axi_awready;
			s_axi_wready <= aw_ok && !s_axi_awready;
			if (s_axi_awready) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (s_axi_awaddr > PLB_OFS_PBCLR) ? PLB_RESP_SLVERR : PLB_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= PLB_RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= (s_axi_araddr > PLB_OFS_PBCLR) ? PLB_RESP_SLVERR : PLB_RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Configuration writes, whole words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ptidx_ff <= 8'h00;
			pacfg_ff <= PLB_RST_CFG;
			pbcfg_ff <= PLB_RST_CFG;
			ctrl_ff <= PLB_RST_CFG;
			pbclk_sel_ff <= 8'h00;
			pbclr_sel_ff <= 8'h00;
		end else if (ce && s_axi_awready) begin
			case (s_axi_awaddr)
				PLB_OFS_PTIDX: ptidx_ff <= s_axi_wdata[7:0];
				PLB_OFS_PACFG: pacfg_ff <= s_axi_wdata;
				PLB_OFS_PBCFG: pbcfg_ff <= s_axi_wdata;
				PLB_OFS_CTRL: ctrl_ff <= s_axi_wdata;
				PLB_OFS_PBCLK: pbclk_sel_ff <= s_axi_wdata[7:0];
				PLB_OFS_PBCLR: pbclr_sel_ff <= s_axi_wdata[7:0];
				default: ptidx_ff <= ptidx_ff;
			endcase
		end
	end

	// Masks clear on reset, so no term is unknown; all-zero masks mean undefined
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int t = 0; t < PLB_NPT; t++) begin
				pt_true_ff[t] <= '0;
				pt_comp_ff[t] <= '0;
			end
		end else if (ce && s_axi_awready && ptidx_ff < 8'(PLB_NPT)) begin
			case (s_axi_awaddr)
				PLB_OFS_PTTRUE_LO: pt_true_ff[ptidx_ff][31:0] <= s_axi_wdata;
				PLB_OFS_PTTRUE_HI: pt_true_ff[ptidx_ff][58:32] <= s_axi_wdata[26:0];
				PLB_OFS_PTCOMP_LO: pt_comp_ff[ptidx_ff][31:0] <= s_axi_wdata;
				PLB_OFS_PTCOMP_HI: pt_comp_ff[ptidx_ff][58:32] <= s_axi_wdata[26:0];
				default: ;
			endcase
		end
	end

	sel_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce |=> memory_block_select == $past(pt[3:0])) else $error("select mismatch");
	io_dec_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !pt[5] |=> io_reg_select == '0) else $error("io select without decoder");
	mrst_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_ff[PLB_CTRL_MRST_EN] |-> !macrocell_reset) else $error("reset not gated");
	pa_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && cell_dir(pacfg_ff, 0) == PLB_DIR_OUT |=> porta_oe[0]) else $error("oe off");
	buried_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && cell_dir(pbcfg_ff, 0) == PLB_DIR_BURIED |=> !portb_oe[0]) else $error("buried drives");
	pa_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && $rose(input_clock_pin) && !pa_if.clr[0] && !pa_if.pre[0]
		|=> pa_if.regv[0] == $past(pa_if.comb[0])) else $error("port A not clocked by pin");
	undef_pt_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!(|(pt_true_ff[PLB_PT_PB_CTL] | pt_comp_ff[PLB_PT_PB_CTL])) |-> !pb_if.pre[0])
		else $error("undefined preset term active");
	bresp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && s_axi_awready |=> s_axi_bvalid) else $error("no write response");

	// Routing, term clear and output path checks
	pin_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cell_dir(pacfg_ff, 0) == PLB_DIR_IN |-> logic_bus[0] == porta_in[0]) else $error("pin not on bus");
	io_onehot_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && pt[5] |=> io_reg_select == (256'h1 << $past(mcu_addr[7:0]))) else $error("io select wrong");
	pb_clr_term_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && pbclr_sel_ff[0] && pt[PLB_PT_PB_CTL+1] |=> !pb_if.regv[0]) else $error("term clear lost");
	pa_comb_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !pacfg_ff[PLB_CF_REG] |=> porta_out[0] == $past(pa_if.comb[0])) else $error("comb out wrong");
	pb_bidir_oe_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && cell_dir(pbcfg_ff, 0) == PLB_DIR_BIDIR |=> portb_oe[0] == $past(pt[PLB_PT_PB_CTL+1]))
		else $error("bidir enable wrong");
endmodule : plb_top

// *** dv/plb_mcu_model.sv ***
/*
 * Far-side model: microcontroller address lines, bus strobes and port pins.
 * Assumes the bench sets the knobs just after a rising aclk edge.
 */
`timescale 1ns/1ns
module plb_mcu_model (
	input wire logic aclk,
	input wire logic lvl,
	input wire logic a8_lo,
	input wire logic [5:0] amid,
	input wire logic clk_lvl,
	input wire logic [7:0] porta_out,
	input wire logic [7:0] porta_oe,
	input wire logic [7:0] portb_out,
	input wire logic [7:0] portb_oe,
	output logic [15:0] mcu_addr,
	output logic mcu_rd,
	output logic mcu_wr,
	output logic [3:0] page_bits,
	output logic input_clock_pin,
	output logic reset_pin,
	output logic chip_sel_in,
	output logic [7:0] portc_in,
	output logic [7:0] portd_in,
	output logic [7:0] porte_in,
	output logic [7:0] porta_in,
	output logic [7:0] portb_in
);
	// Middle address bits are free; a8_lo can force bit 8 low and the clock pin follows clk_lvl; the rest follow one level
	always_ff @(posedge aclk) begin
		mcu_addr <= {{7{lvl}}, lvl & ~a8_lo, amid, lvl, lvl};
		mcu_rd <= lvl;
		mcu_wr <= lvl;
		page_bits <= {4{lvl}};
		input_clock_pin <= clk_lvl;
		reset_pin <= lvl;
		chip_sel_in <= lvl;
		portc_in <= {8{lvl}};
		portd_in <= {8{lvl}};
		porte_in <= {8{lvl}};
	end
	// Pin level: block drives where enabled, external source elsewhere
	assign porta_in = (porta_oe & porta_out) | (~porta_oe & {8{lvl}});
	assign portb_in = (portb_oe & portb_out) | (~portb_oe & {8{lvl}});
endmodule : plb_mcu_model

// *** dv/test_pld_decode_and_macrocells.sv ***
/*
 * Testbench: decode selects, io decoder and port A/B macrocells over AXI4-Lite.
 * Assumes plb_top and the far-side model; cells not under test stay inputs.
 */
`timescale 1ns/1ns
module test_pld_decode_and_macrocells
	import plb_pkg::*;
;
	localparam logic [58:0] ALL = {59{1'b1}};
	localparam logic [1:0] OK = PLB_RESP_OKAY;
	logic aclk, aresetn, lvl, a8_lo, clk_lvl;
	logic [5:0] amid;
	logic [15:0] mcu_addr;
	logic mcu_rd, mcu_wr, input_clock_pin, reset_pin, chip_sel_in;
	logic [3:0] page_bits, memory_block_select;
	logic [7:0] portc_in, portd_in, porte_in, porta_in, porta_out, porta_oe;
	logic [7:0] portb_in, portb_out, portb_oe, awaddr, araddr, sel, idx;
	logic sram_block_select, io_decoder_select;
	logic [1:0] peripheral_mode_select, bresp, rresp, rsp;
	logic [255:0] io_reg_select;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd_v;
	int err_total, check_count, i, k;
	assign sel = {peripheral_mode_select, io_decoder_select, sram_block_select,
		memory_block_select};
	plb_top plb_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .mcu_addr(mcu_addr),
		.mcu_rd(mcu_rd), .mcu_wr(mcu_wr), .page_bits(page_bits),
		.input_clock_pin(input_clock_pin), .reset_pin(reset_pin), .chip_sel_in(chip_sel_in),
		.portc_in(portc_in), .portd_in(portd_in), .porte_in(porte_in), .porta_in(porta_in),
		.porta_out(porta_out), .porta_oe(porta_oe), .portb_in(portb_in),
		.portb_out(portb_out), .portb_oe(portb_oe), .memory_block_select(memory_block_select),
		.sram_block_select(sram_block_select), .io_decoder_select(io_decoder_select),
		.peripheral_mode_select(peripheral_mode_select), .io_reg_select(io_reg_select),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	plb_mcu_model plb_mcu_model_inst (.aclk(aclk), .lvl(lvl), .a8_lo(a8_lo), .amid(amid),
		.clk_lvl(clk_lvl), .porta_out(porta_out), .porta_oe(porta_oe), .portb_out(portb_out),
		.portb_oe(portb_oe), .mcu_addr(mcu_addr), .mcu_rd(mcu_rd), .mcu_wr(mcu_wr),
		.page_bits(page_bits), .input_clock_pin(input_clock_pin), .reset_pin(reset_pin),
		.chip_sel_in(chip_sel_in), .portc_in(portc_in), .portd_in(portd_in),
		.porte_in(porte_in), .porta_in(porta_in), .portb_in(portb_in));
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	task chk(input logic [256:0] g, input logic [256:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task tmo;
		err_total++;
		print_verdict();
	endtask : tmo
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 64 && !(aw && w); n++) begin
			@(posedge aclk);
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		if (!(aw && w)) tmo();
		w = 1'b0;
		for (n = 0; n < 64 && !w; n++) begin
			@(posedge aclk);
			if (bvalid === 1'b1) begin
				w = 1'b1;
				chk(bresp, er);
			end
		end
		if (!w) tmo();
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ar;
		logic got;
		ar = 1'b0;
		got = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 64 && !got; n++) begin
			@(posedge aclk);
			if (!ar && arready === 1'b1) begin
				ar = 1'b1;
				arvalid <= 1'b0;
			end
			if (rvalid === 1'b1) begin
				got = 1'b1;
				d = rdata;
				r = rresp;
			end
		end
		if (!got) tmo();
		@(posedge aclk);
	endtask : rd
	task term(input int t_i, input logic [58:0] t, input logic [58:0] c);
		wr(PLB_OFS_PTIDX, 32'(t_i), OK);
		wr(PLB_OFS_PTTRUE_LO, t[31:0], OK);
		wr(PLB_OFS_PTTRUE_HI, {5'h00, t[58:32]}, OK);
		wr(PLB_OFS_PTCOMP_LO, c[31:0], OK);
		wr(PLB_OFS_PTCOMP_HI, {5'h00, c[58:32]}, OK);
	endtask : term
	task settle;
		repeat (4) @(posedge aclk);
	endtask : settle
	task pulse;
		clk_lvl <= 1'b0;
		settle();
		clk_lvl <= 1'b1;
		settle();
	endtask : pulse
	task rdp(input logic [31:0] m, input logic [31:0] e);
		rd(PLB_OFS_PORTS, rd_v, rsp);
		chk(rd_v & m, e);
	endtask : rdp
	initial begin
		aresetn = 1'b0;
		{lvl, clk_lvl, bready, rready} = 4'hF;
		{a8_lo, amid, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
		err_total = 0;
		check_count = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({sel, porta_oe, portb_oe, bvalid, rvalid}, 26'h0000000);
		rd(PLB_OFS_CTRL, rd_v, rsp);
		chk({rsp, rd_v}, {OK, PLB_RST_CFG});
		rd(8'h34, rd_v, rsp);
		chk({rsp, rd_v}, {PLB_RESP_SLVERR, 32'h00000000});
		wr(8'h34, 32'hFFFFFFFF, PLB_RESP_SLVERR);
		for (i = 0; i < PLB_NPT; i++) term(i, '0, '0);
		for (i = 0; i < 8; i++) begin
			term(i, ALL, '0);
			settle();
			chk(sel, 8'h01 << i);
			term(i, '0, '0);
		end
		term(0, ALL, '0);
		a8_lo <= 1'b1;
		settle();
		chk(sel, 8'h00);
		a8_lo <= 1'b0;
		term(0, '0, ALL);
		{lvl, clk_lvl} <= 2'h0;
		settle();
		chk(sel, 8'h01);
		term(0, ALL, ALL);
		settle();
		chk(sel, 8'h00);
		{lvl, clk_lvl} <= 2'h3;
		term(0, '0, '0);
		term(5, ALL, '0);
		for (k = 0; k < 4; k++) begin
			idx = {6'(k * 21), 2'h3};
			amid <= idx[7:2];
			settle();
			chk({io_decoder_select, io_reg_select}, {1'b1, 256'h1 << idx});
		end
		a8_lo <= 1'b1;
		settle();
		chk({io_decoder_select, io_reg_select}, 257'h0);
		a8_lo <= 1'b0;
		term(5, '0, '0);
		term(10, ALL, '0);
		settle();
		rdp(32'h000000FF, 32'h00000000);
		term(10, '0, '0);
		term(16, ALL, '0);
		settle();
		rdp(32'h000000FF, 32'h00000000);
		pulse();
		rdp(32'h000000FF, 32'h00000001);
		term(9, ALL, '0);
		settle();
		rdp(32'h000000FF, 32'h000000FF);
		term(9, '0, '0);
		term(16, '0, '0);
		wr(PLB_OFS_PACFG, 32'h00000005, OK);
		term(8, ALL, '0);
		settle();
		chk({porta_oe, porta_out[0]}, 9'h003);
		wr(PLB_OFS_PACFG, 32'h0000000D, OK);
		settle();
		chk(porta_oe, 8'h00);
		wr(PLB_OFS_PACFG, 32'h00000004, OK);
		settle();
		chk({porta_oe, porta_out[0]}, 9'h002);
		wr(PLB_OFS_PACFG, 32'h00000009, OK);
		settle();
		chk(porta_oe, 8'h01);
		term(8, '0, '0);
		wr(PLB_OFS_PACFG, 32'h00000009, OK);
		settle();
		chk(porta_oe, 8'h00);
		wr(PLB_OFS_PACFG, 32'h00000000, OK);
		wr(PLB_OFS_PBCLR, 32'h00000001, OK);
		rd(PLB_OFS_PBCLR, rd_v, rsp);
		chk({rsp, rd_v}, {OK, 32'h00000001});
		term(140, ALL, '0);
		settle();
		rdp(32'h00000100, 32'h00000000);
		term(140, '0, '0);
		term(68, ALL, '0);
		pulse();
		rdp(32'h00000100, 32'h00000100);
		term(139, ALL, '0);
		term(140, ALL, '0);
		settle();
		rdp(32'h00000100, 32'h00000000);
		term(140, '0, '0);
		settle();
		rdp(32'h00000100, 32'h00000100);
		term(139, '0, '0);
		wr(PLB_OFS_PBCLK, 32'h00000001, OK);
		term(141, ALL, ALL);
		term(68, '0, '0);
		pulse();
		rdp(32'h00000100, 32'h00000100);
		term(141, ALL, '0);
		settle();
		rdp(32'h00000100, 32'h00000000);
		wr(PLB_OFS_PBCFG, 32'h00000005, OK);
		settle();
		chk({portb_oe, portb_out[0]}, 9'h003);
		wr(PLB_OFS_PBCFG, 32'h00000009, OK);
		settle();
		chk(portb_oe, 8'h00);
		print_verdict();
	end
endmodule : test_pld_decode_and_macrocells
